/* File: core/potaz_core.sv */
`timescale 1ns/10ps
module potaz_core (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic sample_valid_i,
	input wire logic [potaz_pkg::RESULT_W-1:0] sample_i,
	input wire logic als_cycle_start_i,
	input wire logic trim_int_clear_i,
	output logic autozero_req_o,
	output logic photodiode_disconnect_o,
	output logic [potaz_pkg::RESULT_W-1:0] proximity_result_o,
	output logic proximity_result_valid_o,
	output logic trim_busy_o,
	output logic trim_interrupt_flag_o,
	output logic trim_int_o
);
	import potaz_pkg::*;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [RESULT_W-1:0] apply_offset(
		input logic [RESULT_W-1:0] raw,
		input logic [7:0] mag,
		input logic neg);
		logic [RESULT_W:0] sum;
		sum = '0;
		if (neg) begin
			// Clamp at full scale rather than wrap
			sum = {1'b0, raw} + (RESULT_W+1)'(mag);
			apply_offset = sum[RESULT_W] ? '1 : sum[RESULT_W-1:0];
		end else begin
			// Clamp at zero; crosstalk removal never goes negative
			sum = {1'b0, raw} - (RESULT_W+1)'(mag);
			apply_offset = sum[RESULT_W] ? '0 : sum[RESULT_W-1:0];
		end
	endfunction : apply_offset

	function automatic logic [RESULT_W-1:0] target_of(input logic [2:0] sel);
		target_of = (RESULT_W'(1) << sel) - RESULT_W'(1);
	endfunction : target_of

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] offset_magnitude_reg;
	logic offset_sign_bit_reg;
	logic [6:0] autozero_interval_reg;
	logic trim_type_reg;
	logic trim_start_reg;
	logic [2:0] search_target_reg;
	logic zero_result_decrement_enable_reg;
	logic [2:0] proximity_sample_averaging_reg;
	logic trim_done_status_reg;
	logic trim_interrupt_enable_reg;
	logic trim_interrupt_flag_reg;
	logic [7:0] rdata_reg;

	potaz_trim_state_t state_reg;
	logic [7:0] trial_mag_reg;
	logic trial_sign_reg;
	logic [7:0] mask_reg;
	logic restart_reg;

	logic az_first_reg;
	logic [6:0] az_cnt_reg;
	logic az_req_reg;
	logic [RESULT_W-1:0] result_reg;
	logic result_valid_reg;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire wr_mag = reg_wr_i && (reg_addr_i == ADDR_OFFSET_MAG);
	wire wr_sign = reg_wr_i && (reg_addr_i == ADDR_OFFSET_SIGN);
	wire wr_az = reg_wr_i && (reg_addr_i == ADDR_AZ_SCHEDULE);
	wire wr_ctl = reg_wr_i && (reg_addr_i == ADDR_TRIM_CONTROL);
	wire wr_setup = reg_wr_i && (reg_addr_i == ADDR_TRIM_SETUP);
	wire wr_stat = reg_wr_i && (reg_addr_i == ADDR_TRIM_STATUS);
	wire wr_ien = reg_wr_i && (reg_addr_i == ADDR_INT_ENABLE);

	wire busy = (state_reg != TRIM_IDLE);
	wire start_req = wr_ctl && reg_wdata_i[TRIM_START_BIT] && !busy;

	// ------------------------------------------------------------
	// Averaging and offset
	// ------------------------------------------------------------
	wire avg_valid;
	wire [RESULT_W-1:0] avg_result;

	potaz_avg u_avg (
		.ref_clk_i(ref_clk_i),
		.resetn_i(resetn_i),
		.avg_sel_i(proximity_sample_averaging_reg),
		.clear_i(restart_reg),
		.sample_valid_i(sample_valid_i),
		.sample_i(sample_i),
		.result_valid_o(avg_valid),
		.result_o(avg_result)
	);

	// During a trim the trial offset is applied instead of the stored one
	wire [7:0] used_mag = busy ? trial_mag_reg : offset_magnitude_reg;
	wire used_sign = busy ? trial_sign_reg : offset_sign_bit_reg;
	wire [RESULT_W-1:0] adj = apply_offset(avg_result, used_mag, used_sign);
	wire [RESULT_W-1:0] target = target_of(search_target_reg);

	// ------------------------------------------------------------
	// Search
	// ------------------------------------------------------------
	wire keep_bit = trial_sign_reg ? (adj <= target) :
		((adj != '0) && (adj >= target));
	wire [7:0] kept_mag = keep_bit ? trial_mag_reg : (trial_mag_reg & ~mask_reg);
	wire [7:0] next_mask = mask_reg >> 1;
	wire step = avg_valid && (state_reg == TRIM_BIT);
	wire finish = step && mask_reg[0];

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg <= TRIM_IDLE;
			trial_mag_reg <= OFFSET_MAG_RST;
			trial_sign_reg <= 1'b0;
			mask_reg <= SEARCH_MSB_MASK;
			restart_reg <= 1'b0;
		end else begin
			restart_reg <= 1'b0;
			case (state_reg)
				TRIM_IDLE: begin
					if (start_req) begin
						state_reg <= TRIM_SIGN;
						trial_mag_reg <= OFFSET_MAG_RST;
						trial_sign_reg <= 1'b0;
						restart_reg <= 1'b1;
					end
				end
				TRIM_SIGN: begin
					// Below target with no offset means the offset must add
					if (avg_valid) begin
						trial_sign_reg <= (adj < target);
						trial_mag_reg <= SEARCH_MSB_MASK;
						mask_reg <= SEARCH_MSB_MASK;
						restart_reg <= 1'b1;
						state_reg <= TRIM_BIT;
					end
				end
				TRIM_BIT: begin
					if (finish) begin
						trial_mag_reg <= kept_mag;
						state_reg <= TRIM_IDLE;
					end else if (step) begin
						trial_mag_reg <= kept_mag | next_mask;
						mask_reg <= next_mask;
						restart_reg <= 1'b1;
					end
				end
				default: state_reg <= TRIM_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	wire zero_hit = avg_valid && !busy && zero_result_decrement_enable_reg &&
		(adj == '0) && (offset_magnitude_reg != '0);

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			offset_magnitude_reg <= OFFSET_MAG_RST;
			offset_sign_bit_reg <= 1'b0;
			autozero_interval_reg <= AZ_INTERVAL_RST;
			trim_type_reg <= 1'b0;
			trim_start_reg <= 1'b0;
			search_target_reg <= TARGET_RST;
			zero_result_decrement_enable_reg <= 1'b0;
			proximity_sample_averaging_reg <= AVG_RST;
			trim_done_status_reg <= 1'b0;
			trim_interrupt_enable_reg <= 1'b0;
			trim_interrupt_flag_reg <= 1'b0;
		end else begin
			if (finish) begin
				offset_magnitude_reg <= kept_mag;
				offset_sign_bit_reg <= trial_sign_reg;
			end else begin
				if (wr_mag)
					offset_magnitude_reg <= reg_wdata_i;
				else if (zero_hit)
					offset_magnitude_reg <= offset_magnitude_reg - 8'h01;
				if (wr_sign)
					offset_sign_bit_reg <= reg_wdata_i[SIGN_BIT];
			end
			if (wr_az)
				autozero_interval_reg <= reg_wdata_i[6:0];
			// Type is frozen while a trim runs so the search stays consistent
			if (wr_ctl && !busy)
				trim_type_reg <= reg_wdata_i[TRIM_TYPE_BIT];
			if (finish)
				trim_start_reg <= 1'b0;
			else if (start_req)
				trim_start_reg <= 1'b1;
			if (wr_setup) begin
				search_target_reg <= reg_wdata_i[TARGET_MSB:TARGET_LSB];
				zero_result_decrement_enable_reg <= reg_wdata_i[DECR_EN_BIT];
				proximity_sample_averaging_reg <= reg_wdata_i[AVG_MSB:AVG_LSB];
			end
			if (finish)
				trim_done_status_reg <= 1'b1;
			else if (wr_stat && reg_wdata_i[TRIM_DONE_BIT])
				trim_done_status_reg <= 1'b0;
			if (wr_ien)
				trim_interrupt_enable_reg <= reg_wdata_i[TRIM_IEN_BIT];
			if (finish)
				trim_interrupt_flag_reg <= 1'b1;
			else if (trim_int_clear_i)
				trim_interrupt_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	wire [7:0] rd_mux =
		(reg_addr_i == ADDR_OFFSET_MAG) ? offset_magnitude_reg :
		(reg_addr_i == ADDR_OFFSET_SIGN) ? {7'h00, offset_sign_bit_reg} :
		(reg_addr_i == ADDR_AZ_SCHEDULE) ? {1'b0, autozero_interval_reg} :
		(reg_addr_i == ADDR_TRIM_CONTROL) ?
			{2'h0, trim_type_reg, 4'h0, trim_start_reg} :
		(reg_addr_i == ADDR_TRIM_SETUP) ?
			{search_target_reg, 1'b0, zero_result_decrement_enable_reg,
			proximity_sample_averaging_reg} :
		(reg_addr_i == ADDR_TRIM_STATUS) ? {7'h00, trim_done_status_reg} :
		(reg_addr_i == ADDR_INT_ENABLE) ?
			{4'h0, trim_interrupt_enable_reg, 3'h0} : 8'h00;

	// ------------------------------------------------------------
	// Autozero schedule and result
	// ------------------------------------------------------------
	wire az_due = az_first_reg ? (autozero_interval_reg != AZ_NEVER) :
		((autozero_interval_reg != AZ_NEVER) &&
		(autozero_interval_reg != AZ_FIRST_ONLY) &&
		(az_cnt_reg >= autozero_interval_reg));

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= 8'h00;
			az_first_reg <= 1'b1;
			az_cnt_reg <= 7'h00;
			az_req_reg <= 1'b0;
			result_reg <= '0;
			result_valid_reg <= 1'b0;
		end else begin
			if (reg_rd_i)
				rdata_reg <= rd_mux;
			az_req_reg <= als_cycle_start_i && az_due;
			if (als_cycle_start_i) begin
				az_first_reg <= 1'b0;
				// Saturating count avoids a false match after a wrap
				if (az_due)
					az_cnt_reg <= 7'h01;
				else if (az_cnt_reg != 7'h7F)
					az_cnt_reg <= az_cnt_reg + 7'h01;
			end
			result_valid_reg <= avg_valid;
			if (avg_valid)
				result_reg <= adj;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign autozero_req_o = az_req_reg;
	assign photodiode_disconnect_o = busy && trim_type_reg;
	assign proximity_result_o = result_reg;
	assign proximity_result_valid_o = result_valid_reg;
	assign trim_busy_o = busy;
	assign trim_interrupt_flag_o = trim_interrupt_flag_reg;
	assign trim_int_o = trim_interrupt_flag_reg && trim_interrupt_enable_reg;

endmodule : potaz_core

/* File: include/potaz_pkg.sv */
package potaz_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_OFFSET_MAG = 8'hC0;
	localparam logic [7:0] ADDR_OFFSET_SIGN = 8'hC1;
	localparam logic [7:0] ADDR_AZ_SCHEDULE = 8'hD6;
	localparam logic [7:0] ADDR_TRIM_CONTROL = 8'hD7;
	localparam logic [7:0] ADDR_TRIM_SETUP = 8'hD9;
	localparam logic [7:0] ADDR_TRIM_STATUS = 8'hDC;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'hDD;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TRIM_TYPE_BIT = 5;
	localparam int TRIM_START_BIT = 0;
	localparam int TARGET_MSB = 7;
	localparam int TARGET_LSB = 5;
	localparam int DECR_EN_BIT = 3;
	localparam int AVG_MSB = 2;
	localparam int AVG_LSB = 0;
	localparam int TRIM_DONE_BIT = 0;
	localparam int TRIM_IEN_BIT = 3;
	localparam int SIGN_BIT = 0;

	// ------------------------------------------------------------
	// Reset values and schedule codes
	// ------------------------------------------------------------
	localparam logic [6:0] AZ_INTERVAL_RST = 7'h7F;
	localparam logic [6:0] AZ_NEVER = 7'h00;
	localparam logic [6:0] AZ_FIRST_ONLY = 7'h7F;
	localparam logic [2:0] TARGET_RST = 3'h2;
	localparam logic [2:0] AVG_RST = 3'h0;
	localparam logic [7:0] OFFSET_MAG_RST = 8'h00;
	localparam logic [7:0] SEARCH_MSB_MASK = 8'h80;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int RESULT_W = 16;
	localparam int SUM_W = 23;
	localparam int AVG_CNT_W = 8;

	typedef enum logic [1:0] {
		TRIM_IDLE,
		TRIM_SIGN,
		TRIM_BIT
	} potaz_trim_state_t;

endpackage : potaz_pkg

/* File: core/potaz_avg.sv */
`timescale 1ns/10ps
module potaz_avg (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [2:0] avg_sel_i,
	input wire logic clear_i,
	input wire logic sample_valid_i,
	input wire logic [potaz_pkg::RESULT_W-1:0] sample_i,
	output logic result_valid_o,
	output logic [potaz_pkg::RESULT_W-1:0] result_o
);
	import potaz_pkg::*;

	// ------------------------------------------------------------
	// Accumulator
	// ------------------------------------------------------------
	logic [SUM_W-1:0] sum_reg;
	logic [AVG_CNT_W:0] cnt_reg;
	logic [RESULT_W-1:0] result_reg;
	logic valid_reg;

	wire [AVG_CNT_W:0] need = (AVG_CNT_W+1)'(1) << avg_sel_i;
	wire [SUM_W-1:0] sum_next = sum_reg + SUM_W'(sample_i);
	wire [AVG_CNT_W:0] cnt_next = cnt_reg + (AVG_CNT_W+1)'(1);
	wire last = sample_valid_i && (cnt_next >= need);
	wire [SUM_W-1:0] shifted = sum_next >> avg_sel_i;

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sum_reg <= '0;
			cnt_reg <= '0;
			result_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			valid_reg <= last && !clear_i;
			// Clear drops a partial average taken at a stale offset
			if (clear_i || last) begin
				sum_reg <= '0;
				cnt_reg <= '0;
			end else if (sample_valid_i) begin
				sum_reg <= sum_next;
				cnt_reg <= cnt_next;
			end
			if (last && !clear_i)
				result_reg <= shifted[RESULT_W-1:0];
		end
	end

	assign result_valid_o = valid_reg;
	assign result_o = result_reg;

endmodule : potaz_avg

/* File: verification/potaz_asserts.sv */
`timescale 1ns/10ps
module potaz_asserts (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic sample_valid_i,
	input wire logic als_cycle_start_i,
	input wire logic autozero_req_o,
	input wire logic photodiode_disconnect_o,
	input wire logic proximity_result_valid_o,
	input wire logic trim_busy_o,
	input wire logic trim_interrupt_flag_o,
	input wire logic trim_int_o
);
	import potaz_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	sequence start_wr_s;
		reg_wr_i && reg_addr_i == ADDR_TRIM_CONTROL && !trim_busy_o &&
		reg_wdata_i[TRIM_START_BIT];
	endsequence
	sequence trim_end_s;
		$fell(trim_busy_o) && trim_interrupt_flag_o;
	endsequence
	trim_start_a: assert property (start_wr_s |=> trim_busy_o)
		else $error("trim did not start");
	busy_hold_a: assert property ($rose(trim_busy_o) |-> trim_busy_o[*8])
		else $error("trim ended too early");
	end_flag_a: assert property ($fell(trim_busy_o) |-> trim_end_s)
		else $error("trim ended without flag");
	flag_cause_a: assert property ($rose(trim_interrupt_flag_o) |->
		$fell(trim_busy_o)) else $error("flag without trim end");
	pd_disconnect_a: assert property (photodiode_disconnect_o |->
		trim_busy_o) else $error("disconnect outside trim");
	int_gate_a: assert property (trim_int_o |-> trim_interrupt_flag_o)
		else $error("interrupt without flag");
	az_cause_a: assert property (autozero_req_o |->
		$past(als_cycle_start_i)) else $error("autozero without ALS start");
	result_lat_a: assert property (proximity_result_valid_o |->
		$past(sample_valid_i, 2)) else $error("result not two after sample");
endmodule : potaz_asserts

/* File: verification/potaz_front_end.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Front end model, one sample every 4 clocks
// ----------------------------------------
module potaz_front_end (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic run_i,
	input wire logic [15:0] raw_i,
	input wire logic [15:0] step_i,
	output logic sample_valid_o,
	output logic [15:0] sample_o
);
	logic [1:0] gap_reg;
	logic alt_reg;
	logic fire;
	assign fire = run_i && gap_reg == 2'h3;
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gap_reg <= 2'h0;
			alt_reg <= 1'b0;
			sample_valid_o <= 1'b0;
			sample_o <= 16'h0;
		end else begin
			gap_reg <= gap_reg + 2'h1;
			sample_valid_o <= fire;
			alt_reg <= alt_reg ^ fire;
			// Data toggles between samples so stale values never match
			sample_o <= fire ? raw_i + (alt_reg ? step_i : 16'h0) : ~sample_o;
		end
	end
endmodule : potaz_front_end

/* File: verification/potaz_core_tb.sv */
`timescale 1ns/10ps
module potaz_core_tb;
	import potaz_pkg::*;
	logic ref_clk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
	logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
	logic sample_valid_i, als_cycle_start_i = 0, trim_int_clear_i = 0;
	logic [15:0] sample_i, proximity_result_o, raw = 0, step = 0;
	logic autozero_req_o, photodiode_disconnect_o, proximity_result_valid_o;
	logic trim_busy_o, trim_interrupt_flag_o, trim_int_o, run = 0;
	int errors = 0, total_checks = 0;
	potaz_core i_dut (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wr_i,
		.reg_wdata_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .sample_i,
		.als_cycle_start_i, .trim_int_clear_i, .autozero_req_o,
		.photodiode_disconnect_o, .proximity_result_o,
		.proximity_result_valid_o, .trim_busy_o, .trim_interrupt_flag_o,
		.trim_int_o);
	potaz_front_end i_fe (.ref_clk_i, .resetn_i, .run_i(run), .raw_i(raw),
		.step_i(step), .sample_valid_o(sample_valid_i), .sample_o(sample_i));
	always #10 ref_clk_i = ~ref_clk_i;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report;
		if (errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic tick;
		@(posedge ref_clk_i);
		#1;
	endtask : tick
	task automatic wr(logic [7:0] a, logic [7:0] d);
		tick();
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1;
		tick();
		reg_wr_i = 0;
	endtask : wr
	task automatic rchk(string name, logic [7:0] a, logic [7:0] exp);
		tick();
		reg_addr_i = a;
		reg_rd_i = 1;
		tick();
		reg_rd_i = 0;
		chk(name, {8'h00, reg_rdata_o}, {8'h00, exp});
	endtask : rchk
	// Every wait is bounded; a stuck result wait ends the run, a stuck trim wait only logs an error
	task automatic wait_res(output logic [15:0] r);
		int n;
		n = 0;
		while (proximity_result_valid_o !== 1'b1 && n < 2000) begin
			tick();
			n++;
		end
		if (n >= 2000) begin
			chk("result wait", 16'(n), 16'h0000);
			final_report();
		end
		r = proximity_result_o;
		tick();
	endtask : wait_res
	task automatic als(output logic z);
		tick();
		als_cycle_start_i = 1;
		tick();
		als_cycle_start_i = 0;
		z = autozero_req_o;
	endtask : als
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [7:0] a [8] = '{8'hC0, 8'hC1, 8'hD6, 8'hD7, 8'hD9, 8'hDC,
			8'hDD, 8'h00};
		logic [7:0] e [8] = '{8'h00, 8'h00, 8'h7F, 8'h00, 8'h40, 8'h00,
			8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rchk("reset value", a[i], e[i]);
		end
	endtask : t_reset
	task automatic t_autozero;
		logic z;
		logic [15:0] cnt;
		als(z);
		chk("first autozero", z, 1);
		als(z);
		chk("no later autozero", z, 0);
		wr(ADDR_AZ_SCHEDULE, 8'h02);
		cnt = 0;
		repeat (4) begin
			als(z);
			cnt += z;
		end
		chk("autozero every second", cnt, 2);
		wr(ADDR_AZ_SCHEDULE, 8'h00);
		als(z);
		chk("autozero never", z, 0);
	endtask : t_autozero
	task automatic t_average;
		logic [15:0] r;
		raw = 16'd10;
		step = 16'd10;
		for (int n = 1; n < 8; n++) begin
			wr(ADDR_TRIM_SETUP, 8'h40 | 8'(n));
			run = 1;
			wait_res(r);
			wait_res(r);
			run = 0;
			chk("averaged result", r, 16'd15);
		end
		step = 0;
		wr(ADDR_TRIM_SETUP, 8'h40);
	endtask : t_average
	task automatic t_offset;
		logic [15:0] r;
		raw = 16'd20;
		wr(ADDR_OFFSET_MAG, 8'h05);
		run = 1;
		wait_res(r);
		wait_res(r);
		chk("offset subtract", r, 16'd15);
		wr(ADDR_OFFSET_SIGN, 8'h01);
		wait_res(r);
		wait_res(r);
		chk("offset add", r, 16'd25);
		wr(ADDR_OFFSET_SIGN, 8'h00);
		wr(ADDR_TRIM_SETUP, 8'h48);
		raw = 16'd5;
		repeat (3) wait_res(r);
		run = 0;
		rchk("zero decrement", ADDR_OFFSET_MAG, 8'h04);
		wr(ADDR_TRIM_SETUP, 8'h40);
		wr(ADDR_OFFSET_MAG, 8'h00);
	endtask : t_offset
	task automatic t_trim(logic typ, logic [15:0] r, logic [7:0] setup,
		logic [7:0] mag, logic [7:0] sgn);
		int n;
		wr(ADDR_TRIM_SETUP, setup);
		raw = r;
		run = 1;
		wr(ADDR_TRIM_CONTROL, {2'b00, typ, 5'h01});
		chk("trim busy", trim_busy_o, 1);
		chk("disconnect", photodiode_disconnect_o, typ);
		wr(ADDR_TRIM_CONTROL, {2'b00, !typ, 5'h01});
		n = 0;
		while (trim_busy_o !== 1'b0 && n < 2000) begin
			tick();
			n++;
		end
		chk("trim finished", n < 2000, 1);
		run = 0;
		rchk("trim magnitude", ADDR_OFFSET_MAG, mag);
		rchk("trim sign", ADDR_OFFSET_SIGN, sgn);
		rchk("start cleared", ADDR_TRIM_CONTROL, {2'b00, typ, 5'h0});
		rchk("done status", ADDR_TRIM_STATUS, 8'h01);
		wr(ADDR_TRIM_STATUS, 8'h00);
		rchk("zero write kept", ADDR_TRIM_STATUS, 8'h01);
		chk("trim flag", trim_interrupt_flag_o, 1);
		chk("int masked", trim_int_o, 0);
		wr(ADDR_INT_ENABLE, 8'h08);
		chk("int enabled", trim_int_o, 1);
		wr(ADDR_INT_ENABLE, 8'h00);
		wr(ADDR_TRIM_STATUS, 8'h01);
		rchk("done cleared", ADDR_TRIM_STATUS, 8'h00);
		trim_int_clear_i = 1;
		tick();
		trim_int_clear_i = 0;
		tick();
		chk("flag cleared", trim_interrupt_flag_o, 0);
	endtask : t_trim
	// Reset in mid-trim must drop the search and restore the offset, setup and control fields
	task automatic t_midreset;
		wr(ADDR_TRIM_SETUP, 8'h48);
		raw = 16'h0064;
		run = 1;
		wr(ADDR_TRIM_CONTROL, 8'h21);
		chk("busy before reset", trim_busy_o, 1);
		repeat (10) tick();
		resetn_i = 0;
		run = 0;
		repeat (2) tick();
		resetn_i = 1;
		chk("busy after reset", trim_busy_o, 0);
		chk("flag after reset", trim_interrupt_flag_o, 0);
		chk("disconnect after reset", photodiode_disconnect_o, 0);
		rchk("mag after reset", ADDR_OFFSET_MAG, 8'h00);
		rchk("sign after reset", ADDR_OFFSET_SIGN, 8'h00);
		rchk("setup after reset", ADDR_TRIM_SETUP, 8'h40);
		rchk("control after reset", ADDR_TRIM_CONTROL, 8'h00);
	endtask : t_midreset
	initial begin
		repeat (6) @(posedge ref_clk_i);
		#1;
		resetn_i = 1;
		t_reset();
		t_autozero();
		t_average();
		t_offset();
		t_trim(1'b1, 16'd100, 8'h40, 8'h61, 8'h00);
		t_trim(1'b0, 16'd1, 8'h60, 8'h06, 8'h01);
		t_midreset();
		final_report();
	end
endmodule : potaz_core_tb
bind potaz_core potaz_asserts i_chk (.ref_clk_i, .resetn_i, .reg_addr_i,
	.reg_wr_i, .reg_wdata_i, .sample_valid_i, .als_cycle_start_i,
	.autozero_req_o, .photodiode_disconnect_o, .proximity_result_valid_o,
	.trim_busy_o, .trim_interrupt_flag_o, .trim_int_o);
